// ---- core/ucd_pkg.sv ----
// Constants and types of the serial core.
// Assumes APB decode on the low eight address bits.
package ucd_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_DATA  = 8'h00;  // FIFO data window
  localparam logic [7:0] OFS_RXSTS = 8'h04;  // Overrun status
  localparam logic [7:0] OFS_LINE  = 8'h08;  // line_control_register
  localparam logic [7:0] OFS_CTRL  = 8'h0C;  // Masks and loopback
  localparam logic [7:0] OFS_FLAG  = 8'h10;  // Live flags
  localparam logic [7:0] OFS_INT   = 8'h14;  // Interrupt status
  localparam logic [7:0] OFS_DMA   = 8'h18;  // dma_control_register

  // ==========================================================
  // Field positions
  localparam int LINE_PAR_EN   = 16;  // Parity enable
  localparam int LINE_PAR_EVEN = 17;  // Even parity when set
  localparam int LINE_TWO_STOP = 18;  // Two stop bits
  localparam int LINE_FIFO_EN  = 19;  // Full depth when set
  localparam int LINE_BREAK    = 20;  // Hold line low
  localparam int CTRL_LOOP     = 7;   // Loopback enable
  localparam int DMA_RX_EN     = 0;   // rx_dma_enable
  localparam int DMA_TX_EN     = 1;   // tx_dma_enable
  localparam int DMA_ERR_EN    = 2;   // dma_error_report_enable
  localparam int ERR_BRK       = 10;  // Break error in entry
  localparam int ERR_PAR       = 9;   // Parity error in entry
  localparam int ERR_FRM       = 8;   // Framing error in entry

  // ==========================================================
  // Reset values
  localparam logic [20:0] LINE_RST = 21'h08_0000;  // FIFOs on
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [2:0]  DMA_RST  = 3'h0;

  // ==========================================================
  // Timing counts in ticks of the x16 enable, data bits and bit times
  localparam logic [3:0] START_SAMPLE = 4'h7;  // Eighth tick
  localparam logic [3:0] BIT_LAST     = 4'hF;  // Sixteenth tick
  localparam logic [2:0] DATA_LAST    = 3'h7;  // Eight data bits
  localparam logic [5:0] RT_BITS      = 6'h20; // Idle bit times

  // ==========================================================
  // Serial state machines, one-hot
  typedef enum logic [4:0] {
    UCD_IDLE  = 5'h01,
    UCD_START = 5'h02,
    UCD_DATA  = 5'h04,
    UCD_PAR   = 5'h08,
    UCD_STOP  = 5'h10
  } ucd_ser_state_t;

endpackage

// ---- core/ucd_core.sv ----
// Serial core: APB slave, FIFOs, baud divider, serial engines,
// interrupts, DMA port. Assumes inputs sync to clk_i, which is
// also the bit-timing reference.
`timescale 1ns/1ns

// Behaviour
// - separate 16-entry transmit and receive FIFOs
// - one divider times both transmitter and receiver
// - four maskable interrupts from rx, timeout, tx, modem
// - combined interrupt when any unmasked request
// - framing/parity/break flags stored with character
// - overrun sets flag, keeps FIFO contents
// - FIFOs configurable to one byte deep
// - CTS, DCD, DSR feed modem status logic
// - no RI input, no RTS/DTR outputs
// - loopback routes transmit stream into receiver
// - APB decodes status, control and FIFO accesses
// - DMA moves bytes into and out of FIFOs
// - DMA carries eight bits, no status
// - transmit DMA only while its enable set
// - receive DMA only while its enable set
// - errors reach DMA as rx end indication
// - 16-bit down counter reload gives x16 pulse
// - start, data LSB first, parity, stop bits
// - start confirmed on eighth tick, then 16
// - entry bits 10/9/8 errors, 7:0 data
module ucd_core #(
  parameter int FIFO_DEPTH = 16  // Entries per FIFO
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Serial line
  input  wire logic        rxd_i,
  output logic             txd_o,
  // Modem status, active low
  input  wire logic        cts_n_i,
  input  wire logic        dcd_n_i,
  input  wire logic        dsr_n_i,
  // DMA handshake
  output logic             tx_dma_req_o,
  input  wire logic        tx_dma_ack_i,
  input  wire logic [7:0]  tx_dma_data_i,
  output logic             rx_dma_req_o,
  input  wire logic        rx_dma_ack_i,
  output logic      [7:0]  rx_dma_data_o,
  output logic             rx_dma_valid_o,
  output logic             rx_end_indication_o,
  // Interrupts
  output logic             int_modem_o,
  output logic             int_rx_o,
  output logic             int_rt_o,
  output logic             int_tx_o,
  output logic             int_combined_o
);

  localparam int AW = $clog2(FIFO_DEPTH);

  initial begin
    if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH) begin
      $error("FIFO_DEPTH must be a power of two, at least 2");
    end
  end

  // ==========================================================
  // Storage and configuration
  logic [7:0]     tx_mem [FIFO_DEPTH];  // Transmit entries
  logic [10:0]    rx_mem [FIFO_DEPTH];  // Receive entries
  logic [AW-1:0]  tx_wp, tx_rp, rx_wp, rx_rp;
  logic [AW:0]    tx_cnt, rx_cnt, cap;
  logic [20:0]    line_reg;             // Divisor and format
  logic [7:0]     ctrl_reg;             // Masks [3:0], loopback
  logic [2:0]     dma_reg;              // DMA enables
  logic           ovr, msi;             // Sticky flags
  logic [2:0]     modem_prev;           // Last modem levels
  logic [5:0]     rt_cnt;               // Receive idle bit times
  logic [3:0]     bit_div;              // Ticks to bit times
  logic           tx_full, tx_empty, rx_full, rx_empty;
  logic           tx_pop, rx_push;
  logic [10:0]    rx_word;

  // One-byte mode only moves the full mark
  assign cap      = line_reg[ucd_pkg::LINE_FIFO_EN] ?
                    (AW+1)'(FIFO_DEPTH) : (AW+1)'(1);
  assign tx_full  = tx_cnt >= cap;
  assign rx_full  = rx_cnt >= cap;
  assign tx_empty = tx_cnt == '0;
  assign rx_empty = rx_cnt == '0;

  // ==========================================================
  // Baud divider
  logic [15:0] baud_cnt, next_baud_cnt;
  logic        baud_tick_x16, next_tick;

  // Down counter reloads divisor at zero and pulses
  always_comb begin
    next_tick     = baud_cnt == 16'h0000;
    next_baud_cnt = next_tick ? line_reg[15:0] : baud_cnt - 16'h0001;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      baud_cnt      <= 16'h0000;
      baud_tick_x16 <= 1'b0;
    end else begin
      baud_cnt      <= next_baud_cnt;
      baud_tick_x16 <= next_tick;
    end
  end

  // ==========================================================
  // Transmitter
  ucd_pkg::ucd_ser_state_t tx_st, next_tx_st;
  logic [3:0] tx_tk, next_tx_tk;
  logic [2:0] tx_bit, next_tx_bit;
  logic [7:0] tx_sh, next_tx_sh;
  logic       tx_par, next_tx_par, tx_line, next_tx_line;
  logic       tx_end, txd_q;

  assign tx_end = tx_tk == ucd_pkg::BIT_LAST;

  // Shared tick times every bit of the frame
  always_comb begin
    next_tx_st   = tx_st;
    next_tx_tk   = tx_tk;
    next_tx_bit  = tx_bit;
    next_tx_sh   = tx_sh;
    next_tx_par  = tx_par;
    next_tx_line = tx_line;
    tx_pop       = 1'b0;
    if (baud_tick_x16) begin
      next_tx_tk = tx_tk + 4'h1;
      unique case (tx_st)
        ucd_pkg::UCD_IDLE: begin
          next_tx_tk = 4'h0;
          if (!tx_empty) begin  // Start bit
            tx_pop       = 1'b1;
            next_tx_sh   = tx_mem[tx_rp];
            next_tx_par  = ^tx_mem[tx_rp] ^
                           ~line_reg[ucd_pkg::LINE_PAR_EVEN];
            next_tx_line = 1'b0;
            next_tx_st   = ucd_pkg::UCD_START;
          end
        end
        ucd_pkg::UCD_START: if (tx_end) begin
          next_tx_line = tx_sh[0];  // LSB first
          next_tx_bit  = 3'h0;
          next_tx_st   = ucd_pkg::UCD_DATA;
        end
        ucd_pkg::UCD_DATA: if (tx_end) begin
          if (tx_bit != ucd_pkg::DATA_LAST) begin
            next_tx_sh   = tx_sh >> 1;
            next_tx_line = tx_sh[1];
            next_tx_bit  = tx_bit + 3'h1;
          end else if (line_reg[ucd_pkg::LINE_PAR_EN]) begin
            next_tx_line = tx_par;  // Optional parity
            next_tx_st   = ucd_pkg::UCD_PAR;
          end else begin
            next_tx_line = 1'b1;
            next_tx_bit  = 3'h0;
            next_tx_st   = ucd_pkg::UCD_STOP;
          end
        end
        ucd_pkg::UCD_PAR: if (tx_end) begin
          next_tx_line = 1'b1;
          next_tx_bit  = 3'h0;
          next_tx_st   = ucd_pkg::UCD_STOP;
        end
        ucd_pkg::UCD_STOP: if (tx_end) begin
          // Programmed number of stop bits
          if (line_reg[ucd_pkg::LINE_TWO_STOP] && tx_bit == 3'h0) begin
            next_tx_bit = 3'h1;
          end else begin
            next_tx_st = ucd_pkg::UCD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_st   <= ucd_pkg::UCD_IDLE;
      tx_tk   <= 4'h0;
      tx_bit  <= 3'h0;
      tx_sh   <= 8'h00;
      tx_par  <= 1'b0;
      tx_line <= 1'b1;
      txd_q   <= 1'b1;
    end else begin
      tx_st   <= next_tx_st;
      tx_tk   <= next_tx_tk;
      tx_bit  <= next_tx_bit;
      tx_sh   <= next_tx_sh;
      tx_par  <= next_tx_par;
      tx_line <= next_tx_line;
      // Break request forces the line low
      txd_q   <= next_tx_line & ~line_reg[ucd_pkg::LINE_BREAK];
    end
  end

  assign txd_o = txd_q;

  // ==========================================================
  // Receiver
  ucd_pkg::ucd_ser_state_t rx_st, next_rx_st;
  logic [3:0] rx_tk, next_rx_tk;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic       rx_perr, next_rx_perr, rx_allz, next_rx_allz;
  logic       rx_prev, rx_line, rx_end;

  // Loopback takes our own transmit stream
  assign rx_line = ctrl_reg[ucd_pkg::CTRL_LOOP] ? txd_q : rxd_i;
  assign rx_end  = rx_tk == ucd_pkg::BIT_LAST;

  always_comb begin
    next_rx_st   = rx_st;
    next_rx_tk   = rx_tk;
    next_rx_bit  = rx_bit;
    next_rx_sh   = rx_sh;
    next_rx_perr = rx_perr;
    next_rx_allz = rx_allz;
    rx_push      = 1'b0;
    rx_word      = 11'h000;
    if (rx_st == ucd_pkg::UCD_IDLE) begin
      // Only a falling edge starts, so a held break is one word
      if (rx_prev && !rx_line) begin
        next_rx_st = ucd_pkg::UCD_START;
        next_rx_tk = 4'h0;
      end
    end else if (baud_tick_x16) begin
      next_rx_tk = rx_tk + 4'h1;
      unique case (rx_st)
        ucd_pkg::UCD_START: if (rx_tk == ucd_pkg::START_SAMPLE) begin
          // Still low mid-bit, else a false start
          next_rx_st   = rx_line ? ucd_pkg::UCD_IDLE : ucd_pkg::UCD_DATA;
          next_rx_tk   = 4'h0;
          next_rx_bit  = 3'h0;
          next_rx_allz = 1'b1;
          next_rx_perr = 1'b0;
        end
        ucd_pkg::UCD_DATA: if (rx_end) begin
          next_rx_sh   = {rx_line, rx_sh[7:1]};
          next_rx_allz = rx_allz & ~rx_line;
          next_rx_bit  = rx_bit + 3'h1;
          if (rx_bit == ucd_pkg::DATA_LAST) begin
            next_rx_st = line_reg[ucd_pkg::LINE_PAR_EN] ?
                         ucd_pkg::UCD_PAR : ucd_pkg::UCD_STOP;
          end
        end
        ucd_pkg::UCD_PAR: if (rx_end) begin
          next_rx_perr = rx_line ^ (^rx_sh) ^ ~line_reg[ucd_pkg::LINE_PAR_EVEN];
          next_rx_allz = rx_allz & ~rx_line;
          next_rx_st   = ucd_pkg::UCD_STOP;
        end
        ucd_pkg::UCD_STOP: if (rx_end) begin
          // Errors travel with the character
          rx_push                  = 1'b1;
          rx_word[7:0]             = rx_sh;
          rx_word[ucd_pkg::ERR_FRM] = ~rx_line;
          rx_word[ucd_pkg::ERR_PAR] = rx_perr;
          rx_word[ucd_pkg::ERR_BRK] = rx_allz & ~rx_line;
          next_rx_st               = ucd_pkg::UCD_IDLE;
        end
        default: next_rx_st = ucd_pkg::UCD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_st   <= ucd_pkg::UCD_IDLE;
      rx_tk   <= 4'h0;
      rx_bit  <= 3'h0;
      rx_sh   <= 8'h00;
      rx_perr <= 1'b0;
      rx_allz <= 1'b0;
      rx_prev <= 1'b1;
    end else begin
      rx_st   <= next_rx_st;
      rx_tk   <= next_rx_tk;
      rx_bit  <= next_rx_bit;
      rx_sh   <= next_rx_sh;
      rx_perr <= next_rx_perr;
      rx_allz <= next_rx_allz;
      rx_prev <= rx_line;
    end
  end

  // ==========================================================
  // Bus, FIFO pointers, DMA and interrupts
  logic        acc, wr, rd, setup;
  logic        dma_tx_push, dma_rx_pop, tx_push, rx_pop;
  logic [7:0]  tx_wdata;
  logic [AW:0] next_tx_cnt, next_rx_cnt;
  logic [31:0] next_prdata;
  logic        next_slverr, next_ovr, next_msi;
  logic [5:0]  next_rt_cnt;
  logic [3:0]  raw_int, next_int;
  logic [2:0]  modem_now;

  assign modem_now = {~cts_n_i, ~dcd_n_i, ~dsr_n_i};

  always_comb begin
    setup = psel_i & ~penable_i;
    acc   = psel_i & penable_i & pready_o;
    wr    = acc & pwrite_i;
    rd    = acc & ~pwrite_i;
    // DMA handshakes only count while enabled
    dma_tx_push = tx_dma_ack_i & tx_dma_req_o & dma_reg[ucd_pkg::DMA_TX_EN];
    dma_rx_pop  = rx_dma_ack_i & rx_dma_req_o & dma_reg[ucd_pkg::DMA_RX_EN];
    // Either source fills the transmit FIFO
    tx_push  = (dma_tx_push | (wr && paddr_i == ucd_pkg::OFS_DATA)) & ~tx_full;
    tx_wdata = dma_tx_push ? tx_dma_data_i : pwdata_i[7:0];
    rx_pop   = (dma_rx_pop | (rd && paddr_i == ucd_pkg::OFS_DATA)) & ~rx_empty;
    next_tx_cnt = tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    next_rx_cnt = rx_cnt + (AW+1)'(rx_push & ~rx_full) - (AW+1)'(rx_pop);
    // Set wins over a clear written in the same cycle
    next_ovr = (ovr & ~(wr && paddr_i == ucd_pkg::OFS_RXSTS)) |
               (rx_push & rx_full);
    next_msi = (msi & ~(wr && paddr_i == ucd_pkg::OFS_INT && pwdata_i[0])) |
               (modem_now != modem_prev);
    // Idle time since last receive activity
    if (rx_push || rx_pop || rx_empty) begin
      next_rt_cnt = 6'h00;
    end else if (baud_tick_x16 && bit_div == 4'hF && rt_cnt != ucd_pkg::RT_BITS) begin
      next_rt_cnt = rt_cnt + 6'h01;
    end else begin
      next_rt_cnt = rt_cnt;
    end
    // Modem, receive, timeout, transmit sources
    raw_int  = {~tx_full, rt_cnt == ucd_pkg::RT_BITS, ~rx_empty, msi};
    next_int = raw_int & ctrl_reg[3:0];
    // Read data is captured during the setup cycle
    next_slverr = 1'b0;
    next_prdata = 32'h0000_0000;
    unique case (paddr_i)
      ucd_pkg::OFS_DATA:  next_prdata[10:0] = rx_mem[rx_rp];
      ucd_pkg::OFS_RXSTS: next_prdata[0]    = ovr;
      ucd_pkg::OFS_LINE:  next_prdata[20:0] = line_reg;
      ucd_pkg::OFS_CTRL:  next_prdata[7:0]  = ctrl_reg;
      ucd_pkg::OFS_FLAG:  next_prdata[7:0]  = {modem_now,
                            tx_st != ucd_pkg::UCD_IDLE || !tx_empty,
                            tx_empty, rx_full, tx_full, rx_empty};
      ucd_pkg::OFS_INT:   next_prdata[7:0]  = {raw_int, next_int};
      ucd_pkg::OFS_DMA:   next_prdata[2:0]  = dma_reg;
      default:            next_slverr       = 1'b1;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tx_wp <= '0;
      tx_rp <= '0;
      rx_wp <= '0;
      rx_rp <= '0;
      tx_cnt <= '0;
      rx_cnt <= '0;
      line_reg <= ucd_pkg::LINE_RST;
      ctrl_reg <= ucd_pkg::CTRL_RST;
      dma_reg <= ucd_pkg::DMA_RST;
      ovr <= 1'b0;
      msi <= 1'b0;
      modem_prev <= 3'h0;
      rt_cnt <= 6'h00;
      bit_div <= 4'h0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      tx_dma_req_o <= 1'b0;
      rx_dma_req_o <= 1'b0;
      rx_dma_data_o <= 8'h00;
      rx_dma_valid_o <= 1'b0;
      rx_end_indication_o <= 1'b0;
      {int_tx_o, int_rt_o, int_rx_o, int_modem_o} <= 4'h0;
      int_combined_o <= 1'b0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= tx_wdata;
        tx_wp         <= tx_wp + AW'(1);
      end
      if (tx_pop) begin
        tx_rp <= tx_rp + AW'(1);
      end
      // A full FIFO refuses the word, old entries stay
      if (rx_push && !rx_full) begin
        rx_mem[rx_wp] <= rx_word;
        rx_wp         <= rx_wp + AW'(1);
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + AW'(1);
      end
      tx_cnt     <= next_tx_cnt;
      rx_cnt     <= next_rx_cnt;
      ovr        <= next_ovr;
      msi        <= next_msi;
      modem_prev <= modem_now;
      rt_cnt     <= next_rt_cnt;
      if (baud_tick_x16) begin
        bit_div <= bit_div + 4'h1;
      end
      if (wr) begin
        unique case (paddr_i)
          ucd_pkg::OFS_LINE: line_reg <= pwdata_i[20:0];
          ucd_pkg::OFS_CTRL: ctrl_reg <= pwdata_i[7:0];
          ucd_pkg::OFS_DMA:  dma_reg  <= pwdata_i[2:0];
          default: ;
        endcase
      end
      // Zero-wait slave: access phase is the cycle after setup
      pready_o  <= setup;
      pslverr_o <= setup & next_slverr;
      if (setup) begin
        prdata_o <= next_prdata;
      end
      // Requests track space and data after this cycle
      tx_dma_req_o <= dma_reg[ucd_pkg::DMA_TX_EN] & (next_tx_cnt < cap);
      rx_dma_req_o <= dma_reg[ucd_pkg::DMA_RX_EN] & (next_rx_cnt != '0);
      // Byte only, status dropped
      rx_dma_valid_o <= dma_rx_pop & ~rx_empty;
      if (dma_rx_pop && !rx_empty) begin
        rx_dma_data_o <= rx_mem[rx_rp][7:0];
      end
      // Error character flagged to the engine when enabled
      rx_end_indication_o <= dma_rx_pop & ~rx_empty &
                             dma_reg[ucd_pkg::DMA_ERR_EN] & (|rx_mem[rx_rp][10:8]);
      {int_tx_o, int_rt_o, int_rx_o, int_modem_o} <= next_int;
      int_combined_o <= |next_int;
    end
  end

endmodule // ucd_core

// ---- verification/ucd_core_assertions.sv ----
// Checker on the core ports: APB timing, DMA, interrupts.
// Assumes one clock and sync reset.
`timescale 1ns/1ns
module ucd_core_chk (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // APB
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // DMA receive side
  input  wire logic        rx_dma_req_o,
  input  wire logic        rx_dma_ack_i,
  input  wire logic        rx_dma_valid_o,
  input  wire logic        rx_end_indication_o,
  // Interrupts
  input  wire logic        int_modem_o,
  input  wire logic        int_rx_o,
  input  wire logic        int_rt_o,
  input  wire logic        int_tx_o,
  input  wire logic        int_combined_o
);
  // ==========================================================
  // One domain, so clock and disable are set once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // ==========================================================
  // APB: answer exactly one cycle after setup, never held
  property p_ready_once;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready late");
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_err_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("slverr alone");
  // Refused access must not leak stale data
  property p_err_zero;
    pslverr_o |-> prdata_o == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("slverr data");

  // ==========================================================
  // Interrupt combining
  property p_comb_or;
    int_combined_o == (int_modem_o || int_rx_o || int_rt_o || int_tx_o);
  endproperty
  a_comb_or: assert property (p_comb_or) else $error("combined wrong");

  // ==========================================================
  // DMA receive: one answer per accepted ack
  property p_rx_answer;
    rx_dma_req_o && rx_dma_ack_i |=> rx_dma_valid_o;
  endproperty
  a_rx_answer: assert property (p_rx_answer) else $error("no valid");
  property p_rx_cause;
    rx_dma_valid_o |-> $past(rx_dma_ack_i) && $past(rx_dma_req_o);
  endproperty
  a_rx_cause: assert property (p_rx_cause) else $error("valid uncaused");
  property p_end_valid;
    rx_end_indication_o |-> rx_dma_valid_o;
  endproperty
  a_end_valid: assert property (p_end_valid) else $error("end alone");

  // ==========================================================
  // Main scenarios reached
  c_rx_dma: cover property (rx_dma_valid_o);
  c_err: cover property (pslverr_o);
  c_end: cover property (rx_end_indication_o);
endmodule // ucd_core_chk

bind ucd_core ucd_core_chk i_ucd_core_chk (.*);

// ---- verification/ucd_serial_peer.sv ----
// Serial peer: sends frames to the core, decodes its frames.
// Assumes a fixed bit time.
`timescale 1ns/1ns
module ucd_serial_peer #(
  parameter int BIT = 32  // Clocks per serial bit
) (
  // Clock and line
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  // Idle high, as the line's pull-up
  initial line_o = 1'h1;

  // ==========================================================
  // Send n bits LSB first (bit 0 is the start bit), then idle
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i) line_o <= f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
    @(posedge clk_i) line_o <= 1'h1;
    repeat (2 * BIT) @(posedge clk_i);
  endtask

  // ==========================================================
  // Decode one frame; ok stays low if no start bit appears
  task automatic get(output logic [7:0] d, output logic ok);
    ok = 1'h0;
    d = 8'h00;
    for (int t = 0; t < 4000 && !ok; t++) begin
      @(posedge clk_i);
      ok = (line_i === 1'h0);
    end
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      d[i] = line_i;
    end
  endtask
endmodule // ucd_serial_peer

// ---- verification/ucd_core_tb.sv ----
// Self-checking bench: APB tasks, serial peer frames, DMA.
// Assumes a 20 MHz clock.
`timescale 1ns/1ns
module ucd_core_tb;
  // ==========================================================
  // Signals named as the core ports for .* hookup
  localparam int DIV = 1;               // Small divisor keeps runs short
  localparam int BIT = (DIV + 1) * 16;  // Clocks per serial bit
  logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i, tx_dma_data_i, rx_dma_data_o, got;
  logic [31:0] pwdata_i, prdata_o, rd;  // Last read
  logic        pready_o, pslverr_o, er, ok, rxd_i, txd_o;
  logic        cts_n_i, dcd_n_i, dsr_n_i, tx_dma_req_o, tx_dma_ack_i;
  logic        rx_dma_req_o, rx_dma_ack_i, rx_dma_valid_o, rx_end_indication_o;
  logic        int_modem_o, int_rx_o, int_rt_o, int_tx_o, int_combined_o;
  int          miscompares = 0;
  int          cmp_count = 0;

  ucd_core i_ucd_core (.*);
  ucd_serial_peer #(.BIT(BIT)) i_ucd_serial_peer (
    .clk_i(clk_i), .line_i(txd_o), .line_o(rxd_i));

  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================
  // Report and compare
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // ==========================================================
  // APB master: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0000_0000);
    @(posedge clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'h1, w, a, d};
    @(posedge clk_i) penable_i <= 1'h1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      if (pready_o === 1'h1) begin
        {er, rd} = {pslverr_o, prdata_o};
        {psel_i, penable_i} <= 2'h0;
        return;
      end
    end
    miscompares++;
    wrap_up();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a);
    chk(n, e, rd);
  endtask
  // Poll until the receive side holds a word; bounded
  task automatic rx_wait();
    for (int i = 0; i < 200; i++) begin
      apb(1'h0, ucd_pkg::OFS_FLAG);
      if (rd[0] === 1'h0) return;
    end
    miscompares++;
    wrap_up();
  endtask
  // Wait for a DMA request level; tx selects which one
  task automatic wait_req(input logic tx);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk_i);
      if ((tx ? tx_dma_req_o : rx_dma_req_o) === 1'h1) return;
    end
    miscompares++;
    wrap_up();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {psel_i, penable_i, pwrite_i, tx_dma_ack_i, rx_dma_ack_i} = 5'h00;
    {paddr_i, tx_dma_data_i, pwdata_i} = 48'h0000_0000_0000;
    {cts_n_i, dcd_n_i, dsr_n_i} = 3'h7;
    reset_n_i = 1'h0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'h1;
    // Reset values, refused address, DMA idle
    rdc("line", ucd_pkg::OFS_LINE, 20'h8_0000);
    rdc("ctrl", ucd_pkg::OFS_CTRL, 8'h00);
    rdc("dma", ucd_pkg::OFS_DMA, 4'h0);
    apb(1'h0, 8'h1C);
    chk("slverr", 1'h1, er);
    chk("txreq_off", 1'h0, tx_dma_req_o);
    // Plain receive with interrupts unmasked
    wr(ucd_pkg::OFS_LINE, 20'h8_0001);
    wr(ucd_pkg::OFS_CTRL, 8'h0F);
    chk("int_rx_idle", 1'h0, int_rx_o);
    i_ucd_serial_peer.send({3'h7, 8'h5A, 1'h0}, 10);
    rx_wait();
    chk("int_rx", 1'h1, int_rx_o);
    chk("int_tx", 1'h1, int_tx_o);
    chk("int_comb", 1'h1, int_combined_o);
    rdc("data", ucd_pkg::OFS_DATA, 8'h5A);
    // Framing (stop low), parity and break errors kept with the byte
    i_ucd_serial_peer.send({3'h6, 8'hC3, 1'h0}, 10);
    rx_wait();
    rdc("frm", ucd_pkg::OFS_DATA, 12'h1C3);
    wr(ucd_pkg::OFS_LINE, 20'hB_0001);
    i_ucd_serial_peer.send({3'h2, 8'h01, 1'h0}, 11);
    rx_wait();
    rdc("par", ucd_pkg::OFS_DATA, 12'h201);
    wr(ucd_pkg::OFS_LINE, 20'h8_0001);
    i_ucd_serial_peer.send(12'h000, 11);
    rx_wait();
    apb(1'h0, ucd_pkg::OFS_DATA);
    chk("brk", 1'h1, rd[10]);
    // DMA receive of a framing-error byte; tx DMA still off
    wr(ucd_pkg::OFS_DMA, 4'h5);
    i_ucd_serial_peer.send({3'h6, 8'h3C, 1'h0}, 10);
    wait_req(1'h0);
    chk("txreq_gate", 1'h0, tx_dma_req_o);
    @(posedge clk_i) rx_dma_ack_i <= 1'h1;
    @(posedge clk_i) rx_dma_ack_i <= 1'h0;
    @(posedge clk_i);
    chk("rx_valid", 1'h1, rx_dma_valid_o);
    chk("rx_data", 8'h3C, rx_dma_data_o);
    chk("rx_end", 1'h1, rx_end_indication_o);
    // DMA transmit seen on the line by the peer
    wr(ucd_pkg::OFS_DMA, 4'h2);
    wait_req(1'h1);
    {tx_dma_ack_i, tx_dma_data_i} <= {1'h1, 8'hA5};
    @(posedge clk_i) tx_dma_ack_i <= 1'h0;
    i_ucd_serial_peer.get(got, ok);
    chk("tx_start", 1'h1, ok);
    chk("tx_line", 8'hA5, got);
    // Loopback with rx DMA off: data must stay for the bus
    wr(ucd_pkg::OFS_CTRL, 8'h8F);
    wr(ucd_pkg::OFS_DMA, 4'h0);
    wr(ucd_pkg::OFS_DATA, 8'h96);
    rx_wait();
    chk("rxreq_gate", 1'h0, rx_dma_req_o);
    rdc("loop", ucd_pkg::OFS_DATA, 8'h96);
    // One-byte depth: second word overruns, first survives
    wr(ucd_pkg::OFS_CTRL, 8'h0F);
    wr(ucd_pkg::OFS_LINE, 1'h1);
    i_ucd_serial_peer.send({3'h7, 8'h11, 1'h0}, 10);
    i_ucd_serial_peer.send({3'h7, 8'h22, 1'h0}, 10);
    rdc("ovr", ucd_pkg::OFS_RXSTS, 1'h1);
    rdc("keep", ucd_pkg::OFS_DATA, 8'h11);
    // Modem status change raises, then clears
    cts_n_i <= 1'h0;
    repeat (10) @(posedge clk_i);
    chk("int_modem", 1'h1, int_modem_o);
    wr(ucd_pkg::OFS_INT, 1'h1);
    apb(1'h0, ucd_pkg::OFS_INT);
    chk("modem_clr", 1'h0, rd[0]);
    // Full 16-deep transmit FIFO refuses DMA
    wr(ucd_pkg::OFS_LINE, 20'h8_0001);
    wr(ucd_pkg::OFS_DMA, 4'h2);
    for (int i = 0; i < 17; i++) wr(ucd_pkg::OFS_DATA, i);
    apb(1'h0, ucd_pkg::OFS_FLAG);
    chk("tx_full", 1'h1, rd[1]);
    chk("txreq_full", 1'h0, tx_dma_req_o);
    // Second reset in mid-run restores defaults
    reset_n_i <= 1'h0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'h1;
    rdc("line_again", ucd_pkg::OFS_LINE, 20'h8_0000);
    wrap_up();
  end
endmodule // ucd_core_tb
